// *** logic/host_packet_link_map.svh ***
// Constants for the host packet link: timing, framing and packet codes
`ifndef HOST_PACKET_LINK_MAP_SVH
`define HOST_PACKET_LINK_MAP_SVH
`define CLK_HZ        10000000
`define BAUD_FAST     115200
`define BAUD_SLOW     19200
`define DIV_FAST      ((`CLK_HZ + `BAUD_FAST / 2) / `BAUD_FAST)
`define DIV_SLOW      ((`CLK_HZ + `BAUD_SLOW / 2) / `BAUD_SLOW)
`define LAST_BIT      4'h9
`define CRC_INIT      16'hFFFF
`define CRC_POLY      16'h8408
`define CLASS_RESP    2'h1
`define CLASS_RPT     2'h2
`define CLASS_ERR     2'h3
`define CLASS_CMD     2'h0
`define RPT_KEY       8'h80
`define RPT_FAN       8'h81
`define RPT_TEMP      8'h82
`define KEY_LEN       8'h01
`define FAN_LEN       8'h04
`define TEMP_LEN      8'h03
`define REPLY_MS      250
`define FAN_MS        500
`define TEMP_MS       1000
`define CYC_PER_MS    (`CLK_HZ / 1000)
`define REPLY_CYC     (`REPLY_MS * `CYC_PER_MS)
`define FAN_CYC       (`FAN_MS * `CYC_PER_MS)
`define TEMP_CYC      (`TEMP_MS * `CYC_PER_MS)
`endif

// *** logic/host_packet_link_pkg.sv ***
// Types for the host packet link
package host_packet_link_pkg;
   typedef enum logic [4:0] {
      P_TYPE = 5'h01, P_LEN = 5'h02, P_DATA = 5'h04, P_CRCL = 5'h08, P_CRCH = 5'h10
   } parse_type;
   typedef enum logic [5:0] {
      TX_IDLE = 6'h01, TX_TYPE = 6'h02, TX_LEN = 6'h04,
      TX_DATA = 6'h08, TX_CRCL = 6'h10, TX_CRCH = 6'h20
   } tx_state_type;
   typedef enum logic [3:0] {
      SRC_ANS = 4'h1, SRC_KEY = 4'h2, SRC_FAN = 4'h4, SRC_TEMP = 4'h8
   } src_type;
   typedef struct packed {
      logic         rx_meta;
      logic         rx_sync;
      logic         rx_busy;
      logic [9:0]   rx_cnt;
      logic [3:0]   rx_bit;
      logic [7:0]   rx_sh;
      parse_type    ps;
      logic [7:0]   p_type;
      logic [7:0]   p_len;
      logic [7:0]   p_idx;
      logic [15:0]  p_crc;
      logic [7:0]   p_rcrc;
      logic         cmd_valid;
      logic [5:0]   cmd_code;
      logic [7:0]   cmd_len;
      logic         cmd_byte_valid;
      logic [7:0]   cmd_byte;
      logic [7:0]   cmd_byte_idx;
      logic         crc_drop;
      logic         ans_taken;
      logic         ans_pend;
      logic [5:0]   ans_code;
      logic         ans_err;
      logic [7:0]   ans_len;
      logic         wait_on;
      logic [23:0]  wait_cnt;
      logic [11:0]  key_pend;
      logic [3:0]   fan_pend;
      logic [15:0]  temp_pend;
      logic [23:0]  fan_cnt;
      logic [23:0]  temp_cnt;
      tx_state_type ts;
      src_type      src;
      logic [7:0]   t_type;
      logic [7:0]   t_len;
      logic [7:0]   t_idx;
      logic [15:0]  t_crc;
      logic [3:0]   t_sel;
      logic         u_busy;
      logic [9:0]   u_sh;
      logic [9:0]   u_cnt;
      logic [3:0]   u_bit;
      logic         usb_v;
      logic [7:0]   usb_d;
   } state_type;
endpackage

// *** logic/host_packet_link.sv ***
// Packet framer between the display module core and its host link
// Behaviour
// - Boot link 115200 baud, 8N1
// - Baud selectable to 19200, same format
// - Packet: type, count, payload, two check bytes
// - Type top bits class, low six code
// - Illegal content answered with error class packet
// - Payload count 0 to 255, exact
// - Check covers type, count and payload
// - Check low byte first, no padding
// - Each command answered within 250 ms unless a newer command arrives first and restarts the wait
// - Reports interleave freely with responses
// - USB path ignores line settings entirely
// - Key report 0x80, codes 1-12
// - Key reports only for enabled events
// - Fan report 0x81 every half second
// - Fan payload: index, tach, ticks high, low
// - Temperature report 0x82 once per second
// - Answer code equals command code
`timescale 1ns/1ps
`include "host_packet_link_map.svh"
module host_packet_link
   import host_packet_link_pkg::*;
#(
   parameter int unsigned REPLY_CYC = `REPLY_CYC,
   parameter int unsigned FAN_CYC   = `FAN_CYC,
   parameter int unsigned TEMP_CYC  = `TEMP_CYC
) (
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        rstn,
   // Serial pins and path control
   input  wire logic        rx_pin,
   output      logic        tx_pin,
   input  wire logic        usb_sel,
   input  wire logic        baud_19200,
   // USB byte stream
   input  wire logic        usb_rx_valid,
   input  wire logic [7:0]  usb_rx_data,
   output      logic        usb_tx_valid,
   output      logic [7:0]  usb_tx_data,
   input  wire logic        usb_tx_ready,
   // Received commands
   output      logic        cmd_byte_valid,
   output      logic [7:0]  cmd_byte,
   output      logic [7:0]  cmd_byte_idx,
   output      logic        cmd_valid,
   output      logic [5:0]  cmd_code,
   output      logic [7:0]  cmd_len,
   output      logic        crc_drop,
   // Answers from the core
   input  wire logic        ans_valid,
   input  wire logic        ans_error,
   input  wire logic [7:0]  ans_len,
   output      logic        ans_taken,
   output      logic [7:0]  ans_rd_idx,
   input  wire logic [7:0]  ans_rd_data,
   // Key events and masks
   input  wire logic [5:0]  key_press,
   input  wire logic [5:0]  key_release,
   input  wire logic [5:0]  press_mask,
   input  wire logic [5:0]  release_mask,
   // Fan and temperature sources
   input  wire logic [3:0]  fan_report_en,
   output      logic [1:0]  fan_sel,
   input  wire logic [7:0]  tach_edge_count,
   input  wire logic [15:0] fan_ticks,
   input  wire logic [15:0] temp_report_en,
   output      logic [3:0]  temp_sel,
   input  wire logic [15:0] temp_value
);
   state_type  s_reg;
   state_type  s_next;
   logic [9:0] div;
   logic       u_rx_v;
   logic       in_v;
   logic [7:0] in_b;
   logic       sink_free;
   logic       push;
   logic [7:0] tx_byte;
   logic [3:0] pick;

   // One byte into the reflected CRC
   function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
      logic [15:0] r;
      r = c ^ {8'h00, b};
      for (int i = 0; i < 8; i++) begin
         r = r[0] ? ((r >> 1) ^ `CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction

   // Index of lowest set bit
   function automatic logic [3:0] first_set(input logic [15:0] v);
      logic [3:0] k;
      k = 4'h0;
      for (int i = 15; i >= 0; i--) begin
         if (v[i]) begin
            k = 4'(i);
         end
      end
      return k;
   endfunction

   // Output ports straight from state
   assign tx_pin         = s_reg.u_sh[0];
   assign usb_tx_valid   = s_reg.usb_v;
   assign usb_tx_data    = s_reg.usb_d;
   assign cmd_byte_valid = s_reg.cmd_byte_valid;
   assign cmd_byte       = s_reg.cmd_byte;
   assign cmd_byte_idx   = s_reg.cmd_byte_idx;
   assign cmd_valid      = s_reg.cmd_valid;
   assign cmd_code       = s_reg.cmd_code;
   assign cmd_len        = s_reg.cmd_len;
   assign crc_drop       = s_reg.crc_drop;
   assign ans_taken      = s_reg.ans_taken;
   assign ans_rd_idx     = s_reg.t_idx;
   assign fan_sel        = s_reg.t_sel[1:0];
   assign temp_sel       = s_reg.t_sel;

   // Bit period and outgoing byte selection
   always_comb begin
      div = baud_19200 ? 10'(`DIV_SLOW) : 10'(`DIV_FAST);
      sink_free = usb_sel ? (!s_reg.usb_v || usb_tx_ready) : !s_reg.u_busy;
      push = (s_reg.ts != TX_IDLE) && sink_free;
      tx_byte = 8'h00;
      case (s_reg.ts)
         TX_TYPE: tx_byte = s_reg.t_type;
         TX_LEN:  tx_byte = s_reg.t_len;
         TX_CRCL: tx_byte = ~s_reg.t_crc[7:0];
         TX_CRCH: tx_byte = ~s_reg.t_crc[15:8];
         TX_DATA: begin
            case (s_reg.src)
               SRC_ANS: tx_byte = ans_rd_data;
               SRC_KEY: tx_byte = {4'h0, s_reg.t_sel} + 8'h01;
               SRC_FAN: begin
                  case (s_reg.t_idx[1:0])
                     2'h0:    tx_byte = {6'h00, s_reg.t_sel[1:0]};
                     2'h1:    tx_byte = tach_edge_count;
                     2'h2:    tx_byte = fan_ticks[15:8];
                     default: tx_byte = fan_ticks[7:0];
                  endcase
               end
               default: begin
                  case (s_reg.t_idx[1:0])
                     2'h0:    tx_byte = {4'h0, s_reg.t_sel};
                     2'h1:    tx_byte = temp_value[15:8];
                     default: tx_byte = temp_value[7:0];
                  endcase
               end
            endcase
         end
         default: tx_byte = 8'h00;
      endcase
   end

   // Next state
   always_comb begin
      s_next = s_reg;
      u_rx_v = 1'b0;
      pick = 4'h0;
      s_next.cmd_valid = 1'b0;
      s_next.cmd_byte_valid = 1'b0;
      s_next.crc_drop = 1'b0;
      s_next.ans_taken = 1'b0;
      // Pin synchroniser
      s_next.rx_meta = rx_pin;
      s_next.rx_sync = s_reg.rx_meta;
      // Serial receiver, sampled mid-bit
      if (!s_reg.rx_busy) begin
         if (!s_reg.rx_sync) begin
            s_next.rx_busy = 1'b1;
            s_next.rx_cnt = div >> 1;
            s_next.rx_bit = 4'h0;
         end
      end else if (s_reg.rx_cnt == 10'h000) begin
         s_next.rx_cnt = div - 10'h001;
         s_next.rx_bit = s_reg.rx_bit + 4'h1;
         if (s_reg.rx_bit == 4'h0) begin
            s_next.rx_busy = !s_reg.rx_sync;
         end else if (s_reg.rx_bit == `LAST_BIT) begin
            s_next.rx_busy = 1'b0;
            u_rx_v = s_reg.rx_sync;
         end else begin
            s_next.rx_sh = {s_reg.rx_sync, s_reg.rx_sh[7:1]};
         end
      end else begin
         s_next.rx_cnt = s_reg.rx_cnt - 10'h001;
      end
      in_v = usb_sel ? usb_rx_valid : (u_rx_v && !usb_sel);
      in_b = usb_sel ? usb_rx_data : s_reg.rx_sh;
      // Transmit engine, answers first then reports
      if (s_reg.ts == TX_IDLE) begin
         s_next.t_idx = 8'h00;
         s_next.t_crc = `CRC_INIT;
         if (s_reg.ans_pend) begin
            s_next.ans_pend = 1'b0;
            s_next.src = SRC_ANS;
            s_next.t_type = {s_reg.ans_err ? `CLASS_ERR : `CLASS_RESP, s_reg.ans_code};
            s_next.t_len = s_reg.ans_len;
            s_next.ts = TX_TYPE;
         end else if (|s_reg.key_pend) begin
            pick = first_set({4'h0, s_reg.key_pend});
            s_next.key_pend[pick] = 1'b0;
            s_next.src = SRC_KEY;
            s_next.t_type = `RPT_KEY;
            s_next.t_len = `KEY_LEN;
            s_next.t_sel = pick;
            s_next.ts = TX_TYPE;
         end else if (|s_reg.fan_pend) begin
            pick = first_set({12'h000, s_reg.fan_pend});
            s_next.fan_pend[pick[1:0]] = 1'b0;
            s_next.src = SRC_FAN;
            s_next.t_type = `RPT_FAN;
            s_next.t_len = `FAN_LEN;
            s_next.t_sel = pick;
            s_next.ts = TX_TYPE;
         end else if (|s_reg.temp_pend) begin
            pick = first_set(s_reg.temp_pend);
            s_next.temp_pend[pick] = 1'b0;
            s_next.src = SRC_TEMP;
            s_next.t_type = `RPT_TEMP;
            s_next.t_len = `TEMP_LEN;
            s_next.t_sel = pick;
            s_next.ts = TX_TYPE;
         end
      end else if (push) begin
         if (s_reg.ts == TX_TYPE || s_reg.ts == TX_LEN || s_reg.ts == TX_DATA) begin
            s_next.t_crc = crc_step(s_reg.t_crc, tx_byte);
         end
         case (s_reg.ts)
            TX_TYPE: s_next.ts = TX_LEN;
            TX_LEN:  s_next.ts = (s_reg.t_len == 8'h00) ? TX_CRCL : TX_DATA;
            TX_DATA: begin
               s_next.t_idx = s_reg.t_idx + 8'h01;
               if (s_reg.t_idx == s_reg.t_len - 8'h01) begin
                  s_next.ts = TX_CRCL;
               end
            end
            TX_CRCL: s_next.ts = TX_CRCH;
            default: s_next.ts = TX_IDLE;
         endcase
      end
      // Byte sinks
      if (s_reg.usb_v && usb_tx_ready) begin
         s_next.usb_v = 1'b0;
      end
      if (s_reg.u_busy && s_reg.u_cnt == 10'h000) begin
         s_next.u_cnt = div - 10'h001;
         s_next.u_bit = s_reg.u_bit + 4'h1;
         s_next.u_sh = {1'b1, s_reg.u_sh[9:1]};
         s_next.u_busy = (s_reg.u_bit != `LAST_BIT);
      end else if (s_reg.u_busy) begin
         s_next.u_cnt = s_reg.u_cnt - 10'h001;
      end
      if (push && usb_sel) begin
         s_next.usb_v = 1'b1;
         s_next.usb_d = tx_byte;
      end else if (push) begin
         s_next.u_busy = 1'b1;
         s_next.u_sh = {1'b1, tx_byte, 1'b0};
         s_next.u_cnt = div - 10'h001;
         s_next.u_bit = 4'h0;
      end
      // Reply deadline, error stands in for a silent core
      if (s_reg.wait_on) begin
         if (ans_valid) begin
            s_next.wait_on = 1'b0;
            s_next.ans_pend = 1'b1;
            s_next.ans_err = ans_error;
            s_next.ans_len = ans_len;
            s_next.ans_taken = 1'b1;
         end else if (s_reg.wait_cnt == 24'(REPLY_CYC - 1)) begin
            s_next.wait_on = 1'b0;
            s_next.ans_pend = 1'b1;
            s_next.ans_err = 1'b1;
            s_next.ans_len = 8'h00;
         end else begin
            s_next.wait_cnt = s_reg.wait_cnt + 24'h000001;
         end
      end
      // Packet parser
      if (in_v) begin
         case (s_reg.ps)
            P_TYPE: begin
               s_next.p_type = in_b;
               s_next.p_crc = crc_step(`CRC_INIT, in_b);
               s_next.ps = P_LEN;
            end
            P_LEN: begin
               s_next.p_len = in_b;
               s_next.p_crc = crc_step(s_reg.p_crc, in_b);
               s_next.p_idx = 8'h00;
               s_next.ps = (in_b == 8'h00) ? P_CRCL : P_DATA;
            end
            P_DATA: begin
               s_next.p_crc = crc_step(s_reg.p_crc, in_b);
               s_next.cmd_byte_valid = 1'b1;
               s_next.cmd_byte = in_b;
               s_next.cmd_byte_idx = s_reg.p_idx;
               s_next.p_idx = s_reg.p_idx + 8'h01;
               if (s_reg.p_idx == s_reg.p_len - 8'h01) begin
                  s_next.ps = P_CRCL;
               end
            end
            P_CRCL: begin
               s_next.p_rcrc = in_b;
               s_next.ps = P_CRCH;
            end
            default: begin
               s_next.ps = P_TYPE;
               if ({in_b, s_reg.p_rcrc} != ~s_reg.p_crc) begin
                  s_next.crc_drop = 1'b1;
               end else if (s_reg.p_type[7:6] == `CLASS_CMD) begin
                  s_next.cmd_valid = 1'b1;
                  s_next.cmd_code = s_reg.p_type[5:0];
                  s_next.cmd_len = s_reg.p_len;
                  s_next.ans_code = s_reg.p_type[5:0];
                  s_next.wait_on = 1'b1;
                  s_next.wait_cnt = 24'h000000;
               end else begin
                  s_next.ans_code = s_reg.p_type[5:0];
                  s_next.ans_pend = 1'b1;
                  s_next.ans_err = 1'b1;
                  s_next.ans_len = 8'h00;
               end
            end
         endcase
      end
      // Report timers and event capture, a new event beats the clear
      s_next.key_pend = s_next.key_pend | {key_release & release_mask, key_press & press_mask};
      if (s_reg.fan_cnt == 24'(FAN_CYC - 1)) begin
         s_next.fan_cnt = 24'h000000;
         s_next.fan_pend = s_next.fan_pend | fan_report_en;
      end else begin
         s_next.fan_cnt = s_reg.fan_cnt + 24'h000001;
      end
      if (s_reg.temp_cnt == 24'(TEMP_CYC - 1)) begin
         s_next.temp_cnt = 24'h000000;
         s_next.temp_pend = s_next.temp_pend | temp_report_en;
      end else begin
         s_next.temp_cnt = s_reg.temp_cnt + 24'h000001;
      end
   end

   // State register
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         s_reg <= '0;
         s_reg.rx_meta <= 1'b1;
         s_reg.rx_sync <= 1'b1;
         s_reg.ps <= P_TYPE;
         s_reg.ts <= TX_IDLE;
         s_reg.src <= SRC_ANS;
         s_reg.u_sh <= 10'h3FF;
      end else begin
         s_reg <= s_next;
      end
   end

   sequence s_start(src_type w);
      s_reg.ts == TX_IDLE && s_next.ts == TX_TYPE && s_next.src == w;
   endsequence

   property p_frame;
      @(posedge mclk) disable iff (!rstn)
      $rose(s_reg.u_busy) |-> s_reg.u_sh[0] == 1'b0 && s_reg.u_sh[9] == 1'b1;
   endproperty
   a_frame: assert property (p_frame) else $error("bad serial frame");
   property p_baud;
      @(posedge mclk) disable iff (!rstn)
      s_reg.u_busy |-> s_reg.u_cnt < (baud_19200 ? 10'(`DIV_SLOW) : 10'(`DIV_FAST));
   endproperty
   a_baud: assert property (p_baud) else $error("bit period out of range");
   property p_len;
      @(posedge mclk) disable iff (!rstn)
      in_v && s_reg.ps == P_DATA && s_reg.p_idx == s_reg.p_len - 8'h01 |=> s_reg.ps == P_CRCL;
   endproperty
   a_len: assert property (p_len) else $error("payload count not honoured");
   property p_crc_lo;
      @(posedge mclk) disable iff (!rstn)
      push && s_reg.ts == TX_CRCL |-> tx_byte == ~s_reg.t_crc[7:0] ##1 s_reg.ts == TX_CRCH;
   endproperty
   a_crc_lo: assert property (p_crc_lo) else $error("check low byte wrong");
   property p_resp;
      @(posedge mclk) disable iff (!rstn)
      s_start(SRC_ANS) |=> s_reg.t_type[5:0] == $past(s_reg.ans_code)
         && s_reg.t_type[7:6] == ($past(s_reg.ans_err) ? `CLASS_ERR : `CLASS_RESP);
   endproperty
   a_resp: assert property (p_resp) else $error("answer type mismatch");
   property p_key;
      @(posedge mclk) disable iff (!rstn)
      s_start(SRC_KEY) |=> s_reg.t_type == `RPT_KEY && s_reg.t_len == `KEY_LEN;
   endproperty
   a_key: assert property (p_key) else $error("key report header wrong");
   property p_fan;
      @(posedge mclk) disable iff (!rstn)
      s_start(SRC_FAN) |=> s_reg.t_type == `RPT_FAN && s_reg.t_len == `FAN_LEN;
   endproperty
   a_fan: assert property (p_fan) else $error("fan report header wrong");
   property p_temp;
      @(posedge mclk) disable iff (!rstn)
      s_start(SRC_TEMP) |=> s_reg.t_type == `RPT_TEMP;
   endproperty
   a_temp: assert property (p_temp) else $error("temperature report header wrong");
   property p_drop;
      @(posedge mclk) disable iff (!rstn)
      s_reg.crc_drop |-> !s_reg.cmd_valid && !$rose(s_reg.ans_pend);
   endproperty
   a_drop: assert property (p_drop) else $error("bad packet not dropped");
   property p_reply;
      @(posedge mclk) disable iff (!rstn)
      s_reg.wait_on |-> s_reg.wait_cnt < 24'(REPLY_CYC);
   endproperty
   a_reply: assert property (p_reply) else $error("reply deadline exceeded");
   property p_usb;
      @(posedge mclk) disable iff (!rstn)
      usb_sel && !s_reg.u_busy |=> !s_reg.u_busy;
   endproperty
   a_usb: assert property (p_usb) else $error("serial used on usb path");
endmodule

// *** tb/host_sink.sv ***
// Host side model: drains the outgoing byte stream with random stalls
`timescale 1ns/1ps
module host_sink (
   // Clock
   input  wire logic       mclk,
   // Byte stream from the device
   input  wire logic       usb_tx_valid,
   input  wire logic [7:0] usb_tx_data,
   output      logic       usb_tx_ready
);
   logic [7:0] rx_q[$];
   int         seed = 96;
   initial usb_tx_ready = 1'b0;
   // Take bytes on valid and ready, drop ready at random on about one cycle in four, with no limit on a stall
   always @(posedge mclk) begin
      if (usb_tx_valid && usb_tx_ready) begin
         rx_q.push_back(usb_tx_data);
      end
      usb_tx_ready <= ($random(seed) % 4) != 0;
   end
endmodule

// *** tb/tb_top.sv ***
// Self-checking bench for the host packet link
`timescale 1ns/1ps
module tb_top;
   logic        mclk, rstn, usb_sel, usb_rx_valid, ans_valid, ans_error, tx_pin, rx_pin;
   logic        baud_19200;
   logic        usb_tx_valid, usb_tx_ready, cmd_byte_valid, cmd_valid, crc_drop, ans_taken;
   logic [7:0]  usb_rx_data, usb_tx_data, ans_len, ans_rd_idx, ans_rd_data;
   logic [7:0]  cmd_byte, cmd_byte_idx, cmd_len, tach_edge_count;
   logic [5:0]  cmd_code, key_press, key_release, press_mask, release_mask;
   logic [3:0]  fan_report_en, temp_sel;
   logic [1:0]  fan_sel;
   logic [15:0] fan_ticks, temp_report_en, temp_value;
   logic [7:0]  cb_q[$];
   int          errors, samples_checked, n_cmd, n_drop, seed, div_r;
   // Answer payload served from the read index
   assign ans_rd_data = ans_rd_idx ^ 8'hA5;
   host_packet_link #(.REPLY_CYC(200), .FAN_CYC(3000), .TEMP_CYC(6000)) u_host_packet_link (
      .mclk(mclk), .rstn(rstn), .rx_pin(rx_pin), .tx_pin(tx_pin), .usb_sel(usb_sel),
      .baud_19200(baud_19200), .usb_rx_valid(usb_rx_valid), .usb_rx_data(usb_rx_data),
      .usb_tx_valid(usb_tx_valid), .usb_tx_data(usb_tx_data), .usb_tx_ready(usb_tx_ready),
      .cmd_byte_valid(cmd_byte_valid), .cmd_byte(cmd_byte), .cmd_byte_idx(cmd_byte_idx),
      .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_len(cmd_len), .crc_drop(crc_drop),
      .ans_valid(ans_valid), .ans_error(ans_error), .ans_len(ans_len),
      .ans_taken(ans_taken), .ans_rd_idx(ans_rd_idx), .ans_rd_data(ans_rd_data),
      .key_press(key_press), .key_release(key_release), .press_mask(press_mask),
      .release_mask(release_mask), .fan_report_en(fan_report_en), .fan_sel(fan_sel),
      .tach_edge_count(tach_edge_count), .fan_ticks(fan_ticks),
      .temp_report_en(temp_report_en), .temp_sel(temp_sel), .temp_value(temp_value));
   host_sink u_host_sink (.mclk(mclk), .usb_tx_valid(usb_tx_valid),
      .usb_tx_data(usb_tx_data), .usb_tx_ready(usb_tx_ready));
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   // Record received command strobes and payload bytes
   always @(posedge mclk) begin
      if (cmd_valid === 1'b1) n_cmd++;
      if (crc_drop === 1'b1) n_drop++;
      if (cmd_byte_valid === 1'b1) begin
         chk(cmd_byte_idx, cb_q.size());
         cb_q.push_back(cmd_byte);
      end
   end
   function automatic logic [15:0] crc_of(input logic [7:0] b[$]);
      logic [15:0] c;
      c = 16'hFFFF;
      foreach (b[i]) begin
         c = c ^ {8'h00, b[i]};
         repeat (8) c = c[0] ? ((c >> 1) ^ 16'h8408) : (c >> 1);
      end
      return ~c;
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic results();
      $display("checks=%0d mismatches=%0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic send_pkt(input logic [7:0] t, input logic [7:0] p[$], input logic bad);
      logic [7:0]  b[$];
      logic [15:0] c;
      b = p;
      b.push_front(8'(p.size()));
      b.push_front(t);
      c = crc_of(b) ^ {15'h0, bad};
      b.push_back(c[7:0]);
      b.push_back(c[15:8]);
      cb_q = {};
      foreach (b[i]) begin
         @(posedge mclk);
         usb_rx_valid <= usb_sel;
         usb_rx_data <= b[i];
         for (int j = 0; j < 10 && !usb_sel; j++) begin
            rx_pin <= 1'({1'b1, b[i], 1'b0} >> j);
            repeat (div_r) @(posedge mclk);
         end
      end
      @(posedge mclk);
      usb_rx_valid <= 1'b0;
      repeat (4) @(posedge mclk);
   endtask
   task automatic get_pkt(output logic [7:0] t, output logic [7:0] l, output logic [7:0] q[$]);
      logic [7:0] b[$];
      logic [7:0] lo;
      int         k;
      k = 0;
      while ((u_host_sink.rx_q.size() < 2 ||
              u_host_sink.rx_q.size() < u_host_sink.rx_q[1] + 4) && k < 8000) begin
         @(posedge mclk);
         k++;
      end
      if (k == 8000) begin
         errors++;
         results();
      end
      t = u_host_sink.rx_q.pop_front();
      l = u_host_sink.rx_q.pop_front();
      q = {};
      repeat (l) q.push_back(u_host_sink.rx_q.pop_front());
      lo = u_host_sink.rx_q.pop_front();
      b = q;
      b.push_front(l);
      b.push_front(t);
      chk({u_host_sink.rx_q.pop_front(), lo}, crc_of(b));
   endtask
   task automatic cmd_test(input logic [5:0] code, input int len, input int mode);
      logic [7:0] p[$], q[$], t, l;
      int         n0, k;
      p = {};
      repeat (len) p.push_back(8'($random(seed)));
      n0 = n_cmd;
      send_pkt({2'b00, code}, p, 1'b0);
      chk(n_cmd, n0 + 1);
      chk({cmd_code, cmd_len}, {code, 8'(len)});
      foreach (p[i]) chk(cb_q[i], p[i]);
      if (mode < 2) begin
         @(posedge mclk);
         ans_valid <= 1'b1;
         ans_error <= mode[0];
         ans_len <= 8'(len);
         k = 0;
         while (ans_taken !== 1'b1 && k < 50) begin
            @(posedge mclk);
            #1;
            k++;
         end
         chk(k < 50, 1);
         @(posedge mclk);
         ans_valid <= 1'b0;
      end
      get_pkt(t, l, q);
      chk(t, {(mode == 0) ? 2'b01 : 2'b11, code});
      chk(l, (mode < 2) ? len : 0);
      foreach (q[i]) chk(q[i], 8'(i) ^ 8'hA5);
   endtask
   initial begin
      logic [7:0]  q[$], t, l, exp_q[$];
      logic [9:0]  sb;
      logic [1:0]  fi;
      logic [3:0]  ti;
      int          k, nf, nt;
      seed = 96;
      {rstn, usb_sel, usb_rx_valid, ans_valid, ans_error, baud_19200, rx_pin} = 7'h01;
      {usb_rx_data, ans_len, tach_edge_count} = 24'h0;
      {key_press, key_release, press_mask, release_mask} = 24'h0;
      {fan_report_en, fan_ticks, temp_report_en, temp_value} = 52'h0;
      repeat (2) @(posedge mclk);
      rstn <= 1'b1;
      usb_sel <= 1'b1;
      // Answered, refused and unanswered commands with boundary lengths
      cmd_test(6'h00, 0, 0);
      cmd_test(6'h3F, 255, 0);
      repeat (3) cmd_test(6'($random(seed)), $unsigned($random(seed)) % 40, 0);
      cmd_test(6'($random(seed)), 5, 1);
      cmd_test(6'($random(seed)), 2, 2);
      $display("command tests done");
      // Bad check value is dropped silently
      k = n_drop;
      send_pkt(8'h07, '{8'h11, 8'h22}, 1'b1);
      repeat (300) @(posedge mclk);
      chk(n_drop, k + 1);
      chk(u_host_sink.rx_q.size(), 0);
      // Packet of a device class gets an error answer
      k = n_cmd;
      send_pkt(8'h45, '{8'h01}, 1'b0);
      get_pkt(t, l, q);
      chk({t, l, 8'(n_cmd - k)}, 24'hC50000);
      $display("drop tests done");
      // Key events, all enabled then random masks
      for (int r = 0; r < 2; r++) begin
         press_mask <= (r == 0) ? 6'h3F : 6'($random(seed));
         release_mask <= (r == 0) ? 6'h3F : 6'($random(seed));
         @(posedge mclk);
         exp_q = {};
         for (int i = 0; i < 12; i++) begin
            if (i < 6 ? press_mask[i] : release_mask[i - 6]) exp_q.push_back(8'(i + 1));
            @(posedge mclk);
            key_press <= (i < 6) ? 6'(1 << i) : 6'h00;
            key_release <= (i >= 6) ? 6'(1 << (i - 6)) : 6'h00;
            @(posedge mclk);
            {key_press, key_release} <= 12'h000;
         end
         foreach (exp_q[i]) begin
            get_pkt(t, l, q);
            chk({t, l, q[0]}, {16'h8001, exp_q[i]});
         end
         repeat (200) @(posedge mclk);
         chk(u_host_sink.rx_q.size(), 0);
      end
      $display("key tests done");
      // Dropped packet in, key report character out, both line speeds
      usb_sel <= 1'b0;
      press_mask <= 6'h01;
      for (int r = 0; r < 2; r++) begin
         baud_19200 <= 1'(r);
         div_r = r ? 521 : 87;
         send_pkt(8'h2A, '{8'h3C, 8'hC3}, 1'b1);
         chk(n_drop, 2 + r);
         chk({cb_q[0], cb_q[1]}, 16'h3CC3);
         @(posedge mclk);
         key_press <= 6'h01;
         @(posedge mclk);
         key_press <= 6'h00;
         k = 0;
         while (tx_pin !== 1'b0 && k < 99) begin
            @(posedge mclk);
            #1;
            k++;
         end
         chk(k < 99, 1);
         repeat (div_r / 2) @(posedge mclk);
         for (int i = 0; i < 10; i++) begin
            sb[i] = tx_pin;
            repeat (div_r) @(posedge mclk);
         end
         chk(sb, 10'h300);
         repeat (42 * div_r) @(posedge mclk);
      end
      usb_sel <= 1'b1;
      baud_19200 <= 1'b0;
      $display("serial test done");
      // Periodic fan and temperature reports
      fi = 2'($random(seed));
      ti = 4'($random(seed));
      {tach_edge_count, fan_ticks, temp_value} <= 40'($random(seed)) ^ {$random(seed), 8'h5A};
      fan_report_en <= 4'(1 << fi);
      temp_report_en <= 16'(1 << ti);
      repeat (6100) @(posedge mclk);
      {fan_report_en, temp_report_en} <= 20'h0;
      repeat (200) @(posedge mclk);
      {nf, nt} = 64'h0;
      while (u_host_sink.rx_q.size() > 0) begin
         get_pkt(t, l, q);
         if (t === 8'h81) begin
            nf++;
            chk({l, q[0], q[1], q[2], q[3]}, {8'h04, 6'h0, fi, tach_edge_count, fan_ticks});
         end else begin
            nt++;
            chk({t, l, q[0], q[1], q[2]}, {16'h8203, 4'h0, ti, temp_value});
         end
      end
      chk(nf inside {[2:3]}, 1);
      chk(nt inside {[1:2]}, 1);
      $display("report tests done");
      results();
   end
endmodule
